// [include/rtc_pkg.sv]
// constants shared by the real-time clock timekeeping and interval alarm logic
package rtc_pkg;
    // special-function register addresses
    localparam logic [7:0] ADDR_CONFIG = 8'hA1;
    localparam logic [7:0] ADDR_FRAC = 8'hA2;
    localparam logic [7:0] ADDR_SEC = 8'hA3;
    localparam logic [7:0] ADDR_MIN = 8'hA4;
    localparam logic [7:0] ADDR_HOUR = 8'hA5;
    localparam logic [7:0] ADDR_INTERVAL = 8'hA6;
    localparam logic [7:0] ADDR_KEY = 8'hC1;

    // configuration field positions
    localparam int CFG_MIDNIGHT_BIT = 7;
    localparam int CFG_DAY_MODE_BIT = 6;
    localparam int CFG_TIMEBASE_HI = 5;
    localparam int CFG_TIMEBASE_LO = 4;
    localparam int CFG_SINGLE_BIT = 3;
    localparam int CFG_ALARM_BIT = 2;
    localparam int CFG_TIMER_EN_BIT = 1;
    localparam int CFG_RESERVED_BIT = 0;

    // reset values
    localparam logic [7:0] CONFIG_RESET = 8'h01;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] KEY_RESET = 8'h00;

    // unlock key for the timekeeping counters
    localparam logic [7:0] UNLOCK_KEY = 8'hEA;

    // counter limits
    localparam logic [7:0] FRAC_LAST = 8'h7F;
    localparam logic [7:0] SEC_LAST = 8'h3B;
    localparam logic [7:0] MIN_LAST = 8'h3B;
    localparam logic [7:0] HOUR_LAST_24 = 8'h17;
    localparam logic [7:0] HOUR_LAST_256 = 8'hFF;

    // timing: crystal rate and crystal edges per 1/128 s tick
    localparam int XTAL_HZ = 32768;
    localparam int FRAC_PER_SEC = 128;
    localparam int XTAL_PER_FRAC = XTAL_HZ / FRAC_PER_SEC;

    typedef enum logic [1:0] {
        TB_FRAC = 2'b00,
        TB_SEC = 2'b01,
        TB_MIN = 2'b10,
        TB_HOUR = 2'b11
    } timebase_t;

    typedef enum logic [1:0] {
        IT_IDLE = 2'b00,
        IT_COUNT = 2'b01,
        IT_DONE = 2'b10
    } interval_state_t;
endpackage

// [rtl/xtal_tick_gen.sv]
// crystal clock synchroniser and 1/128 second tick divider
module xtal_tick_gen #(
    parameter int DIV = rtc_pkg::XTAL_PER_FRAC
) (
    input wire logic ref_clk, // system clock
    input wire logic rst, // power-on reset
    input wire logic xtal_clk_in, // 32.768 kHz crystal clock pin
    output logic frac_tick // one-cycle pulse every 1/128 s
);
    import rtc_pkg::*;

    localparam int CW = $clog2(DIV);

    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic [CW-1:0] div_r;
    logic rise;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync1_r <= xtal_clk_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign rise = sync2_r & ~prev_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_r <= '0;
            frac_tick <= 1'b0;
        end else begin
            frac_tick <= 1'b0;
            if (rise) begin
                if (div_r == CW'(DIV - 1)) begin
                    div_r <= '0;
                    frac_tick <= 1'b1;
                end else begin
                    div_r <= div_r + CW'(1);
                end
            end
        end
    end
endmodule

// [rtl/interval_alarm_timer.sv]
// 8-bit interval timer that raises an alarm pulse after a programmed count
module interval_alarm_timer #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk, // system clock
    input wire logic rst, // power-on or system reset
    input wire logic run, // timer enable and clock enable both set
    input wire logic base_tick, // selected time base pulse
    input wire logic single, // one interval only
    input wire logic [WIDTH-1:0] limit, // programmed interval length
    output logic [WIDTH-1:0] count, // current interval count
    output logic alarm_pulse // one-cycle pulse when interval elapses
);
    import rtc_pkg::*;

    interval_state_t state_r;
    logic [WIDTH-1:0] count_nxt;

    assign count_nxt = count + WIDTH'(1);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= IT_IDLE;
            count <= '0;
            alarm_pulse <= 1'b0;
        end else begin
            alarm_pulse <= 1'b0;
            case (state_r)
                IT_IDLE: begin
                    count <= '0;
                    if (run) begin
                        state_r <= IT_COUNT;
                    end
                end
                IT_COUNT: begin
                    if (!run) begin
                        state_r <= IT_IDLE;
                        count <= '0;
                    end else if (base_tick) begin
                        if (count_nxt == limit) begin
                            alarm_pulse <= 1'b1;
                            count <= '0;
                            state_r <= single ? IT_DONE : IT_COUNT;
                        end else begin
                            count <= count_nxt;
                        end
                    end
                end
                IT_DONE: begin
                    // waits here until software drops the enable
                    count <= '0;
                    if (!run) begin
                        state_r <= IT_IDLE;
                    end
                end
                default: begin
                    state_r <= IT_IDLE;
                    count <= '0;
                end
            endcase
        end
    end
endmodule

// [rtl/rtc_timekeeper.sv]
// real-time clock timekeeping chain, interval alarm and register file
module rtc_timekeeper #(
    parameter int XTAL_DIV = rtc_pkg::XTAL_PER_FRAC
) (
    input wire logic ref_clk, // 40 MHz system clock
    input wire logic rst, // power-on reset, synchronous
    input wire logic sys_rst, // watchdog or external reset
    input wire logic xtal_clk_in, // 32.768 kHz crystal clock pin
    input wire logic clock_counting_enable, // clock enable, gates only the interval timer
    input wire logic [7:0] sfr_addr, // register address
    input wire logic sfr_wr, // write strobe
    input wire logic sfr_rd, // read strobe
    input wire logic [7:0] sfr_wdata, // write data
    output logic [7:0] sfr_rdata, // read data, one cycle after strobe
    output logic sfr_hit, // read address maps to this block, one cycle later
    output logic rtc_irq_pending, // shared interrupt request
    output logic [rtc_pkg::CFG_MIDNIGHT_BIT:0] rtc_configuration_out // config view
);
    import rtc_pkg::*;

    logic [7:0] rtc_configuration_r;
    logic [7:0] fraction_second_count_r;
    logic [7:0] one_hz_tally_r;
    logic [7:0] sixty_second_tally_r;
    logic [7:0] hour_count_r;
    logic [7:0] alarm_interval_length_r;
    logic [7:0] write_unlock_key_r;

    logic frac_tick;
    logic sec_tick;
    logic min_tick;
    logic hour_tick;
    logic day_wrap;
    logic base_tick;
    logic alarm_pulse;
    logic interval_run;
    logic unlocked;

    logic day_mode_select;
    logic single_interval_select;
    logic interval_timer_enable;
    timebase_t interval_timebase_select;

    logic wr_config;
    logic wr_frac;
    logic wr_sec;
    logic wr_min;
    logic wr_hour;
    logic wr_interval;
    logic wr_key;

    logic [7:0] hour_last;
    logic midnight_nxt;
    logic alarm_nxt;

    // address decode used only by the read path for sfr_hit; writes compare addresses directly
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            ADDR_CONFIG, ADDR_FRAC, ADDR_SEC, ADDR_MIN,
            ADDR_HOUR, ADDR_INTERVAL, ADDR_KEY: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // counter step with wrap after its last value
    function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] last);
        if (v >= last) begin
            step = COUNT_RESET;
        end else begin
            step = v + 8'h01;
        end
    endfunction

    assign day_mode_select = rtc_configuration_r[CFG_DAY_MODE_BIT];
    assign single_interval_select = rtc_configuration_r[CFG_SINGLE_BIT];
    assign interval_timer_enable = rtc_configuration_r[CFG_TIMER_EN_BIT];
    assign interval_timebase_select =
        timebase_t'(rtc_configuration_r[CFG_TIMEBASE_HI:CFG_TIMEBASE_LO]);
    assign rtc_configuration_out = rtc_configuration_r;

    assign unlocked = (write_unlock_key_r == UNLOCK_KEY);

    assign wr_config = sfr_wr && (sfr_addr == ADDR_CONFIG);
    assign wr_frac = sfr_wr && (sfr_addr == ADDR_FRAC) && unlocked;
    assign wr_sec = sfr_wr && (sfr_addr == ADDR_SEC) && unlocked;
    assign wr_min = sfr_wr && (sfr_addr == ADDR_MIN) && unlocked;
    assign wr_hour = sfr_wr && (sfr_addr == ADDR_HOUR) && unlocked;
    assign wr_interval = sfr_wr && (sfr_addr == ADDR_INTERVAL);
    assign wr_key = sfr_wr && (sfr_addr == ADDR_KEY);

    xtal_tick_gen #(
        .DIV(XTAL_DIV)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .xtal_clk_in(xtal_clk_in),
        .frac_tick(frac_tick)
    );

    // carry chain: each stage carries only when the one below wraps
    // fraction wrap into seconds
    assign sec_tick = frac_tick && (fraction_second_count_r >= FRAC_LAST);
    assign min_tick = sec_tick && (one_hz_tally_r >= SEC_LAST);
    assign hour_tick = min_tick && (sixty_second_tally_r >= MIN_LAST);

    assign hour_last = day_mode_select ? HOUR_LAST_24 : HOUR_LAST_256;
    assign day_wrap = hour_tick && (hour_count_r >= hour_last);

    // counters reset only by rst, never by sys_rst
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fraction_second_count_r <= COUNT_RESET;
        end else if (wr_frac) begin
            fraction_second_count_r <= sfr_wdata;
        end else if (frac_tick) begin
            fraction_second_count_r <= step(fraction_second_count_r, FRAC_LAST);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            one_hz_tally_r <= COUNT_RESET;
        end else if (wr_sec) begin
            one_hz_tally_r <= sfr_wdata;
        end else if (sec_tick) begin
            one_hz_tally_r <= step(one_hz_tally_r, SEC_LAST);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sixty_second_tally_r <= COUNT_RESET;
        end else if (wr_min) begin
            sixty_second_tally_r <= sfr_wdata;
        end else if (min_tick) begin
            sixty_second_tally_r <= step(sixty_second_tally_r, MIN_LAST);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hour_count_r <= COUNT_RESET;
        end else if (wr_hour) begin
            hour_count_r <= sfr_wdata;
        end else if (hour_tick) begin
            hour_count_r <= step(hour_count_r, hour_last);
        end
    end

    // key register; a system reset relocks the counters
    always_ff @(posedge ref_clk) begin
        if (rst || sys_rst) begin
            write_unlock_key_r <= KEY_RESET;
        end else if (wr_key) begin
            write_unlock_key_r <= sfr_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            alarm_interval_length_r <= COUNT_RESET;
        end else if (wr_interval) begin
            alarm_interval_length_r <= sfr_wdata;
        end
    end

    always_comb begin
        case (interval_timebase_select)
            TB_FRAC: base_tick = frac_tick;
            TB_SEC: base_tick = sec_tick;
            TB_MIN: base_tick = min_tick;
            TB_HOUR: base_tick = hour_tick;
            default: base_tick = 1'b0;
        endcase
    end

    assign interval_run = interval_timer_enable && clock_counting_enable;

    interval_alarm_timer #(
        .WIDTH(8)
    ) u_interval (
        .ref_clk(ref_clk),
        .rst(rst || sys_rst),
        .run(interval_run),
        .base_tick(base_tick),
        .single(single_interval_select),
        .limit(alarm_interval_length_r),
        .count(),
        .alarm_pulse(alarm_pulse)
    );

    // flags: software may write 0 to clear, writing 1 keeps the old value,
    // and a hardware event in the same cycle wins over the clear
    always_comb begin
        midnight_nxt = rtc_configuration_r[CFG_MIDNIGHT_BIT];
        alarm_nxt = rtc_configuration_r[CFG_ALARM_BIT];
        if (wr_config) begin
            midnight_nxt = midnight_nxt & sfr_wdata[CFG_MIDNIGHT_BIT];
            alarm_nxt = alarm_nxt & sfr_wdata[CFG_ALARM_BIT];
        end
        if (day_wrap) begin
            midnight_nxt = 1'b1;
        end
        if (alarm_pulse) begin
            alarm_nxt = 1'b1;
        end
    end

    // configuration: day mode survives system resets, other controls do not
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rtc_configuration_r <= CONFIG_RESET;
        end else if (sys_rst) begin
            rtc_configuration_r <= {1'b0, rtc_configuration_r[CFG_DAY_MODE_BIT],
                CONFIG_RESET[CFG_TIMEBASE_HI:0]};
        end else begin
            if (wr_config) begin
                rtc_configuration_r[CFG_DAY_MODE_BIT] <= sfr_wdata[CFG_DAY_MODE_BIT];
                rtc_configuration_r[CFG_TIMEBASE_HI:CFG_TIMEBASE_LO] <=
                    sfr_wdata[CFG_TIMEBASE_HI:CFG_TIMEBASE_LO];
                rtc_configuration_r[CFG_SINGLE_BIT] <= sfr_wdata[CFG_SINGLE_BIT];
                rtc_configuration_r[CFG_TIMER_EN_BIT] <= sfr_wdata[CFG_TIMER_EN_BIT];
                rtc_configuration_r[CFG_RESERVED_BIT] <= sfr_wdata[CFG_RESERVED_BIT];
            end
            rtc_configuration_r[CFG_MIDNIGHT_BIT] <= midnight_nxt;
            rtc_configuration_r[CFG_ALARM_BIT] <= alarm_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rtc_irq_pending <= 1'b0;
        end else if (sys_rst) begin
            // system reset clears both flags, so the request must drop with them
            rtc_irq_pending <= 1'b0;
        end else begin
            rtc_irq_pending <= midnight_nxt || alarm_nxt;
        end
    end

    // read path; unmapped addresses read zero and leave sfr_hit low
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
            sfr_hit <= 1'b0;
        end else if (sfr_rd) begin
            sfr_hit <= is_mapped(sfr_addr);
            case (sfr_addr)
                ADDR_CONFIG: sfr_rdata <= rtc_configuration_r;
                ADDR_FRAC: sfr_rdata <= fraction_second_count_r;
                ADDR_SEC: sfr_rdata <= one_hz_tally_r;
                ADDR_MIN: sfr_rdata <= sixty_second_tally_r;
                ADDR_HOUR: sfr_rdata <= hour_count_r;
                ADDR_INTERVAL: sfr_rdata <= alarm_interval_length_r;
                ADDR_KEY: sfr_rdata <= write_unlock_key_r;
                default: sfr_rdata <= 8'h00;
            endcase
        end else begin
            sfr_hit <= 1'b0;
        end
    end
endmodule

// [testbench/rtc_timekeeper_asserts.sv]
// port-level checks on the timekeeper flags, resets and register reads
module rtc_timekeeper_asserts (
    input wire logic ref_clk, // clock
    input wire logic rst, // power-on reset
    input wire logic sys_rst, // system reset
    input wire logic clock_counting_enable, // interval timer clock enable
    input wire logic [7:0] sfr_addr, // address
    input wire logic sfr_wr, // write strobe
    input wire logic sfr_rd, // read strobe
    input wire logic [7:0] sfr_wdata, // write data
    input wire logic [7:0] sfr_rdata, // read data
    input wire logic sfr_hit, // mapped read
    input wire logic rtc_irq_pending, // interrupt request
    input wire logic [rtc_pkg::CFG_MIDNIGHT_BIT:0] rtc_configuration_out // config
);
    timeunit 1ns;
    timeprecision 100ps;
    import rtc_pkg::*;
    logic [CFG_MIDNIGHT_BIT:0] cfg;
    logic cfg_wr;
    logic mapped;
    assign cfg = rtc_configuration_out;
    assign cfg_wr = sfr_wr && sfr_addr == ADDR_CONFIG;
    assign mapped = (sfr_addr >= ADDR_CONFIG && sfr_addr <= ADDR_INTERVAL) || sfr_addr == ADDR_KEY;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    AST_IRQ_FLAGS: assert property (rtc_irq_pending == (cfg[7] | cfg[2]))
        else $error("irq differs from flags");
    AST_POR_VALUES: assert property ($fell(rst) |-> cfg == CONFIG_RESET && !sfr_rdata)
        else $error("bad values after power-on reset");
    AST_SYS_RST_KEEP: assert property (sys_rst |=> cfg[6] == $past(cfg[6]) && cfg[0])
        else $error("system reset lost day mode");
    AST_ALARM_NO_SW_SET: assert property (
        cfg_wr && sfr_wdata[2] && !cfg[2] && !cfg[1] && !$past(cfg[1]) |=> !cfg[2])
        else $error("software set the alarm flag");
    AST_ALARM_HOLD: assert property (
        cfg[2] && !(cfg_wr && !sfr_wdata[2]) && !sys_rst |=> cfg[2])
        else $error("alarm flag dropped without a clear");
    AST_MID_HOLD: assert property (
        cfg[7] && !(cfg_wr && !sfr_wdata[7]) && !sys_rst |=> cfg[7])
        else $error("midnight flag dropped without a clear");
    AST_ALARM_NEEDS_TIMER_EN: assert property (
        !cfg[1] && !$past(cfg[1]) && !$past(cfg[1], 2) && !$past(cfg[1], 3)
        |-> !$rose(cfg[2]))
        else $error("alarm while timer disabled");
    AST_ALARM_NEEDS_RUN: assert property (
        !clock_counting_enable && !$past(clock_counting_enable, 2)
        && !$past(clock_counting_enable, 3) |-> !$rose(cfg[2]))
        else $error("alarm while clock enable low");
    AST_READ_HIT: assert property (sfr_rd |=> sfr_hit == $past(mapped) && (sfr_hit || !sfr_rdata))
        else $error("read hit or unmapped data wrong");
    COV_MIDNIGHT: cover property ($rose(cfg[7]));
    COV_ALARM: cover property ($rose(cfg[2]));
    COV_SYS_RST: cover property (sys_rst ##2 sfr_hit);
endmodule

bind rtc_timekeeper rtc_timekeeper_asserts u_asserts (.ref_clk(ref_clk), .rst(rst),
    .sys_rst(sys_rst), .clock_counting_enable(clock_counting_enable), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .rtc_irq_pending(rtc_irq_pending),
    .rtc_configuration_out(rtc_configuration_out));

// [testbench/rtc_timekeeping_interval_alarm_tb.sv]
// self-checking bench for the timekeeping chain and interval alarm
module rtc_timekeeping_interval_alarm_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rtc_pkg::*;
    logic ref_clk, rst, sys_rst, xtal_clk_in, clock_counting_enable;
    logic sfr_wr, sfr_rd, sfr_hit, rtc_irq_pending, rd_d;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, cfg_out;
    logic [8:0] exp_q[$];
    string name_q[$];
    int err_total, checks, cycles;
    logic [31:0] lfsr_r;

    rtc_timekeeper #(.XTAL_DIV(4)) u_dut (.ref_clk(ref_clk), .rst(rst), .sys_rst(sys_rst),
        .xtal_clk_in(xtal_clk_in), .clock_counting_enable(clock_counting_enable),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .rtc_irq_pending(rtc_irq_pending),
        .rtc_configuration_out(cfg_out));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // crystal sped up so a second is 4096 cycles; its edges fall on ref_clk falling edges, never on rising edges
    initial begin
        xtal_clk_in = 1'b0;
        forever #100 xtal_clk_in = ~xtal_clk_in;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic is_mapped(input logic [7:0] a);
        return (a >= ADDR_CONFIG && a <= ADDR_INTERVAL) || a == ADDR_KEY;
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [8:0] e, input logic [8:0] g);
        checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        sfr_wr <= w;
        sfr_rd <= r;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({is_mapped(a), e});
        name_q.push_back($sformatf("read %h", a));
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic idle(input int n);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wait_irq(input int n, input logic e);
        int i;
        idle(1);
        for (i = 0; i < n; i++) begin
            if (rtc_irq_pending === 1'b1)
                break;
            @(posedge ref_clk);
        end
        cmp("irq", {8'h00, e}, {8'h00, rtc_irq_pending});
    endtask
    task automatic preload(input logic [7:0] h);
        wr(ADDR_KEY, UNLOCK_KEY);
        wr(ADDR_FRAC, 8'h00);
        wr(ADDR_HOUR, h);
        wr(ADDR_MIN, MIN_LAST);
        wr(ADDR_SEC, SEC_LAST);
        wr(ADDR_FRAC, FRAC_LAST);
        wr(ADDR_KEY, KEY_RESET);
    endtask

    // read results land one cycle after the strobe
    always @(posedge ref_clk) begin
        rd_d <= sfr_rd;
        if (rd_d === 1'b1) begin
            if (exp_q.size() == 0)
                cmp("unexpected read", 9'h000, 9'h1FF);
            else
                cmp(name_q.pop_front(), exp_q.pop_front(), {sfr_hit, sfr_rdata});
        end
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            summarize();
        end
    end

    initial begin
        logic [7:0] h, v;
        logic [1:0] tb;
        int k;
        {rst, sys_rst, sfr_wr, sfr_rd, clock_counting_enable, rd_d} = 6'b100000;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        lfsr_r = 32'h00015727;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        idle(1);
        cmp("config out", {1'b0, CONFIG_RESET}, {1'b0, cfg_out});
        rd(ADDR_CONFIG, CONFIG_RESET);
        for (k = 0; k < 6; k++)
            rd(ADDR_FRAC + 8'(k), 8'h00);
        rd(8'hA0, 8'h00);
        lfsr_r = lfsr_next(lfsr_r);
        h = lfsr_r[7:0];
        v = lfsr_r[15:8];
        wr(ADDR_HOUR, h);
        rd(ADDR_HOUR, 8'h00);
        wr(ADDR_KEY, UNLOCK_KEY);
        wr(ADDR_HOUR, h);
        rd(ADDR_HOUR, h);
        wr(ADDR_KEY, KEY_RESET);
        wr(ADDR_HOUR, ~h);
        rd(ADDR_HOUR, h);
        wr(ADDR_INTERVAL, v);
        wr(ADDR_CONFIG, 8'h41);
        idle(1);
        sys_rst <= 1'b1;
        idle(2);
        sys_rst <= 1'b0;
        rd(ADDR_HOUR, h);
        rd(ADDR_INTERVAL, v);
        rd(ADDR_CONFIG, 8'h41);
        idle(1);
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        rd(ADDR_HOUR, 8'h00);
        rd(ADDR_CONFIG, CONFIG_RESET);
        $display("test registers done");
        wr(ADDR_CONFIG, 8'h41);
        preload(HOUR_LAST_24);
        wait_irq(100, 1'b1);
        rd(ADDR_FRAC, 8'h00);
        rd(ADDR_SEC, 8'h00);
        rd(ADDR_MIN, 8'h00);
        rd(ADDR_HOUR, 8'h00);
        rd(ADDR_CONFIG, 8'hC1);
        // a system reset drops the flags, so the shared request must fall too
        sys_rst <= 1'b1;
        idle(1);
        sys_rst <= 1'b0;
        wait_irq(4, 1'b0);
        wr(ADDR_CONFIG, 8'h01);
        preload(HOUR_LAST_24);
        idle(100);
        rd(ADDR_HOUR, 8'h18);
        rd(ADDR_CONFIG, 8'h01);
        preload(HOUR_LAST_256);
        wait_irq(100, 1'b1);
        rd(ADDR_HOUR, 8'h00);
        $display("test rollover done");
        wr(ADDR_INTERVAL, 8'h03);
        wr(ADDR_CONFIG, 8'h03);
        wait_irq(300, 1'b0);
        clock_counting_enable <= 1'b1;
        wait_irq(200, 1'b1);
        wr(ADDR_CONFIG, 8'h03);
        wait_irq(80, 1'b0);
        wait_irq(40, 1'b1);
        wr(ADDR_CONFIG, 8'h01);
        wr(ADDR_CONFIG, 8'h0B);
        wait_irq(200, 1'b1);
        wr(ADDR_CONFIG, 8'h0B);
        wait_irq(300, 1'b0);
        wr(ADDR_CONFIG, 8'h01);
        wait_irq(300, 1'b0);
        wr(ADDR_CONFIG, 8'h05);
        rd(ADDR_CONFIG, 8'h01);
        $display("test interval done");
        wr(ADDR_INTERVAL, 8'h01);
        for (k = 0; k < 4; k++) begin
            tb = 2'(k);
            wr(ADDR_CONFIG, 8'h01);
            wr(ADDR_KEY, UNLOCK_KEY);
            wr(ADDR_FRAC, 8'h00);
            wr(ADDR_MIN, MIN_LAST);
            wr(ADDR_SEC, SEC_LAST);
            wr(ADDR_KEY, KEY_RESET);
            wr(ADDR_CONFIG, {2'b00, tb, 4'h3});
            wait_irq(100, tb == 2'b00);
            wr(ADDR_KEY, UNLOCK_KEY);
            wr(ADDR_FRAC, FRAC_LAST);
            wr(ADDR_KEY, KEY_RESET);
            wait_irq(100, 1'b1);
        end
        $display("test timebase done");
        idle(4);
        summarize();
    end
endmodule
